/* File: csda_core.sv */
/*
  Execution unit for two core instructions: an unsigned compare of a file
  register with the working register that skips when the file register is
  less, and the decimal adjust of the working register. Includes its
  parameter package and an APB slave for the working register, flags, bank
  select, operands and status.
  Assumes one 200 MHz clock, APB signals synchronous to it, and that
  software supplies the file register contents and says whether the
  instruction after the compare is two words long.
*/
// The register addresses and the APB register port were left to the implementer.
// What this block does
// - Compare file register with W unsigned; skip next instruction if less; flags untouched.
// - Compare opcode: upper seven bits fixed, access bit, eight-bit file address.
// - Access bit zero uses access bank; one uses bank select plus operand.
// - Compare is one word; one cycle without skip, two cycles with skip.
// - Skipping a two-word instruction costs three cycles, both words discarded.
// - Every skip cycle does nothing in all four phases.
// - Decimal adjust adds six to low nibble if above nine or digit carry set.
// - Operand-free decimal adjust fixes W in place after packed BCD addition.

`timescale 1ns/10ps
`default_nettype none

// ==================================================
// Package
package csda_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OPCODE = 8'h04;
  localparam logic [7:0] OFF_WREG = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0C;
  localparam logic [7:0] OFF_BANK = 8'h10;
  localparam logic [7:0] OFF_FDATA = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam logic [7:0] OFF_DADDR = 8'h1C;
  localparam int CTRL_START = 0;
  localparam int CTRL_TWO_WORD = 1;
  localparam int FLAG_C = 0;
  localparam int FLAG_DCARRY = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_SKIP = 1;
  localparam int STAT_ILLEGAL = 2;
  localparam int STAT_CYC_LSB = 4;
  localparam logic [15:0] CMP_MASK = 16'hFE00;
  localparam logic [15:0] CMP_CODE = 16'h6000;
  localparam logic [15:0] DECADJ_CODE = 16'h0007;
  localparam int CMP_ABIT = 8;
  localparam logic [3:0] ACCESS_BANK = 4'h0;
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [3:0] BCD_ADJ = 4'h6;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [1:0] Q_READ = 2'h1;
  localparam logic [1:0] Q_PROC = 2'h2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_OPCODE = 16'h0000;
  localparam logic [3:0] QCYC = 4'h4;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_SKIP = 2'b10
  } csda_state_e;
endpackage : csda_pkg

module csda_core
  import csda_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ==================================================
  // Register file
  csda_state_e state_r;
  logic [1:0] q_r;
  logic [7:0] w_r;
  logic c_r;
  logic dcarry_r;
  logic [3:0] bank_r;
  logic [7:0] fdata_r;
  logic [15:0] opcode_r;
  logic two_word_r;
  logic [7:0] op_r;
  logic [11:0] daddr_r;
  logic skip_r;
  logic illegal_r;
  logic [1:0] cycles_r;
  logic skip_left_r;
  logic busy;
  logic wr_en;
  logic start;
  logic addr_ok;
  logic is_cmp;
  logic is_decadj;
  logic [11:0] daddr_nxt;

  assign busy = (state_r != ST_IDLE);
  assign wr_en = psel && penable && pwrite;
  // Writes to operands while busy are dropped so an instruction sees stable inputs
  assign start = wr_en && !busy && (paddr == OFF_CTRL) && pwdata[CTRL_START];
  assign pready = 1'b1;
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= OFF_DADDR);
  assign pslverr = psel && penable && !addr_ok;

  always_comb
  begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      OFF_CTRL: prdata[CTRL_TWO_WORD] = two_word_r;
      OFF_OPCODE: prdata[15:0] = opcode_r;
      OFF_WREG: prdata[7:0] = w_r;
      OFF_FLAGS: prdata[FLAG_DCARRY:FLAG_C] = {dcarry_r, c_r};
      OFF_BANK: prdata[3:0] = bank_r;
      OFF_FDATA: prdata[7:0] = fdata_r;
      OFF_STAT: prdata[STAT_CYC_LSB+1:0] = {cycles_r, 1'b0, illegal_r, skip_r, busy};
      OFF_DADDR: prdata[11:0] = daddr_r;
      default: prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      opcode_r <= RST_OPCODE;
      two_word_r <= 1'b0;
      bank_r <= ACCESS_BANK;
      fdata_r <= RST_BYTE;
    end
    else if (wr_en && !busy)
    begin
      unique case (paddr)
        OFF_CTRL: two_word_r <= pwdata[CTRL_TWO_WORD];
        OFF_OPCODE: opcode_r <= pwdata[15:0];
        OFF_BANK: bank_r <= pwdata[3:0];
        OFF_FDATA: fdata_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ==================================================
  // Decode
  assign is_cmp = ((opcode_r & CMP_MASK) == CMP_CODE);
  assign is_decadj = (opcode_r == DECADJ_CODE);
  assign daddr_nxt = opcode_r[CMP_ABIT] ? {bank_r, opcode_r[7:0]}
                                        : {ACCESS_BANK, opcode_r[7:0]};

  // ==================================================
  // Phase sequencer: Q1..Q4 are four core_clk cycles
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= ST_IDLE;
      q_r <= 2'h0;
      skip_left_r <= 1'b0;
      cycles_r <= 2'h0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (start)
          begin
            state_r <= ST_EXEC;
            q_r <= 2'h0;
            cycles_r <= 2'h1;
          end
        end
        ST_EXEC:
        begin
          q_r <= q_r + 2'h1;
          if (q_r == Q_LAST)
          begin
            if (skip_r)
            begin
              state_r <= ST_SKIP;
              skip_left_r <= two_word_r;
              cycles_r <= two_word_r ? 2'h3 : 2'h2;
            end
            else
              state_r <= ST_IDLE;
          end
        end
        ST_SKIP:
        begin
          q_r <= q_r + 2'h1;
          if (q_r == Q_LAST)
          begin
            if (skip_left_r)
              skip_left_r <= 1'b0;
            else
              state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ==================================================
  // Compare datapath: read in Q2, decide in Q3
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      op_r <= RST_BYTE;
      daddr_r <= 12'h000;
      skip_r <= 1'b0;
      illegal_r <= 1'b0;
    end
    else if (start)
    begin
      skip_r <= 1'b0;
      illegal_r <= !(is_cmp || is_decadj);
    end
    else if (state_r == ST_EXEC && q_r == Q_READ && is_cmp)
    begin
      op_r <= fdata_r;
      daddr_r <= daddr_nxt;
    end
    else if (state_r == ST_EXEC && q_r == Q_PROC && is_cmp)
    begin
      skip_r <= (op_r < w_r);
    end
  end

  // ==================================================
  // Working register and flags; skip cycles never touch them
  logic [4:0] lo_sum;
  logic [4:0] hi_sum;
  logic lo_fix;
  logic hi_fix;

  always_comb
  begin
    lo_fix = (w_r[3:0] > BCD_LIMIT) || dcarry_r;
    lo_sum = {1'b0, w_r[3:0]} + (lo_fix ? {1'b0, BCD_ADJ} : 5'h00);
    hi_fix = (w_r[7:4] > BCD_LIMIT) || c_r;
    hi_sum = {1'b0, w_r[7:4]} + (hi_fix ? {1'b0, BCD_ADJ} : 5'h00) + {4'h0, lo_sum[4]};
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      w_r <= RST_BYTE;
      c_r <= 1'b0;
      dcarry_r <= 1'b0;
    end
    else if (state_r == ST_EXEC && q_r == Q_LAST && is_decadj)
    begin
      w_r <= {hi_sum[3:0], lo_sum[3:0]};
      // Decimal adjust only ever sets carry; it holds when no high fix is needed
      if (hi_fix)
        c_r <= 1'b1;
    end
    else if (wr_en && !busy && paddr == OFF_WREG)
      w_r <= pwdata[7:0];
    else if (wr_en && !busy && paddr == OFF_FLAGS)
    begin
      c_r <= pwdata[FLAG_C];
      dcarry_r <= pwdata[FLAG_DCARRY];
    end
  end

  // ==================================================
  // Checks
  logic [3:0] busy_cnt;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      busy_cnt <= 4'h0;
    else if (start)
      busy_cnt <= 4'h0;
    else if (busy)
      busy_cnt <= busy_cnt + 4'h1;
  end

  a_cmp_unsigned: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == ST_EXEC && q_r == Q_PROC && is_cmp |=> skip_r == ($past(op_r) < $past(w_r)))
    else $error("compare skip decision wrong");
  a_cmp_flags: assert property (@(posedge core_clk) disable iff (!rstn)
    busy && is_cmp |=> $stable(c_r) && $stable(dcarry_r))
    else $error("compare changed flags");
  a_cmp_decode: assert property (@(posedge core_clk) disable iff (!rstn)
    start && is_cmp |=> !illegal_r && state_r == ST_EXEC)
    else $error("compare opcode not decoded");
  a_bank_addr: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == ST_EXEC && q_r == Q_READ && is_cmp |=>
      daddr_r == {($past(opcode_r[CMP_ABIT]) ? $past(bank_r) : ACCESS_BANK), $past(opcode_r[7:0])})
    else $error("data address wrong");
  a_one_cycle: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(busy) && !skip_r |-> busy_cnt == QCYC && cycles_r == 2'h1)
    else $error("no-skip length wrong");
  a_skip_cycle: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(busy) && skip_r && !two_word_r |-> busy_cnt == 4'h8 && cycles_r == 2'h2)
    else $error("skip length wrong");
  a_two_word: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(busy) && skip_r && two_word_r |-> busy_cnt == 4'hC && cycles_r == 2'h3)
    else $error("two-word skip length wrong");
  a_skip_idle: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == ST_SKIP |=> $stable(w_r) && $stable(c_r) && $stable(dcarry_r))
    else $error("skip cycle did work");
  a_decadj_low: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == ST_EXEC && q_r == Q_LAST && is_decadj |=>
      w_r[3:0] == (($past(w_r[3:0]) > BCD_LIMIT || $past(dcarry_r))
                   ? 4'($past(w_r[3:0]) + BCD_ADJ) : $past(w_r[3:0])))
    else $error("low nibble adjust wrong");
  a_decadj_carry: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == ST_EXEC && q_r == Q_LAST && is_decadj |=>
      c_r == ($past(c_r) || $past(w_r[7:4]) > BCD_LIMIT))
    else $error("carry adjust wrong");
  c_cmp_skip: cover property (@(posedge core_clk) disable iff (!rstn)
    $fell(busy) && skip_r && !two_word_r);
  c_cmp_two: cover property (@(posedge core_clk) disable iff (!rstn)
    $fell(busy) && skip_r && two_word_r);
  c_decadj_carry: cover property (@(posedge core_clk) disable iff (!rstn)
    state_r == ST_EXEC && q_r == Q_LAST && is_decadj && hi_fix);

endmodule : csda_core

`default_nettype wire

/* File: csda_core_tb.sv */
/*
  Self-checking bench for csda_core: APB tasks set operands, launch compare
  and decimal adjust runs, and compare status, address and results.
  Assumes the csda_pkg register map and an APB slave on core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module csda_core_tb
  import csda_pkg::*;
();
  // ==================================================
  // Signals
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int total_checks = 0;

  always #2.5 core_clk = ~core_clk;

  csda_core DUT (
    .core_clk(core_clk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  // ==================================================
  // Tasks
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Entered just after a rising edge; one idle edge after each transfer
  // so psel is never assigned twice in one time step
  task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    // Only the watchdog ends a wait for pready
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  // Launch, read busy at once, optionally try a write while busy, then poll
  // until done; the poke only lands inside busy when the run is a skip run
  task run(input logic [15:0] op, input logic two, input logic poke);
    apb(1'b1, OFF_OPCODE, {16'h0, op});
    apb(1'b1, OFF_CTRL, {30'h0, two, 1'b1});
    apb(1'b0, OFF_STAT, 32'h0);
    check("busy", {31'h0, rd[STAT_BUSY]}, 32'h1);
    if (poke) apb(1'b1, OFF_WREG, 32'h000000AA);
    apb(1'b0, OFF_STAT, 32'h0);
    while (rd[STAT_BUSY] !== 1'b0)
      apb(1'b0, OFF_STAT, 32'h0);
  endtask : run

  task cmp_case(input logic [7:0] f, w, input logic a, input logic [3:0] bank, input logic two);
    logic skip;
    logic [1:0] cyc;
    skip = f < w;
    cyc = skip ? (two ? 2'h3 : 2'h2) : 2'h1;
    apb(1'b1, OFF_WREG, {24'h0, w});
    apb(1'b1, OFF_FDATA, {24'h0, f});
    apb(1'b1, OFF_BANK, {28'h0, bank});
    apb(1'b1, OFF_FLAGS, 32'h00000003);
    run(CMP_CODE | {7'h00, a, f}, two, skip);
    check("skip", {31'h0, rd[STAT_SKIP]}, {31'h0, skip});
    check("illegal", {31'h0, rd[STAT_ILLEGAL]}, 32'h0);
    check("cycles", {30'h0, rd[STAT_CYC_LSB +: 2]}, {30'h0, cyc});
    apb(1'b0, OFF_DADDR, 32'h0);
    check("daddr", rd, {20'h0, (a ? bank : ACCESS_BANK), f});
    apb(1'b0, OFF_FLAGS, 32'h0);
    check("flags", rd, 32'h00000003);
    apb(1'b0, OFF_WREG, 32'h0);
    check("wreg", rd, {24'h0, w});
  endtask : cmp_case

  // Expected result built nibble by nibble from the adjust rules
  task decadj_case(input logic [7:0] w, input logic c, dcarry);
    logic [4:0] lo;
    logic [4:0] hi;
    logic cn;
    lo = {1'b0, w[3:0]};
    if (w[3:0] > BCD_LIMIT || dcarry) lo = lo + 5'h06;
    hi = {1'b0, w[7:4]} + {4'h0, lo[4]};
    cn = c;
    if (w[7:4] > BCD_LIMIT || c)
    begin
      hi = hi + 5'h06;
      cn = 1'b1;
    end
    apb(1'b1, OFF_WREG, {24'h0, w});
    apb(1'b1, OFF_FLAGS, {30'h0, dcarry, c});
    run(DECADJ_CODE, 1'b0, 1'b0);
    check("decadj_cycles", {30'h0, rd[STAT_CYC_LSB +: 2]}, 32'h1);
    apb(1'b0, OFF_WREG, 32'h0);
    check("decadj_w", rd, {24'h0, hi[3:0], lo[3:0]});
    apb(1'b0, OFF_FLAGS, 32'h0);
    check("decadj_flags", rd, {30'h0, dcarry, cn});
  endtask : decadj_case

  task end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // ==================================================
  // Sequence
  initial
  begin
    #50000;
    mismatches++;
    end_of_test();
  end

  initial
  begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, OFF_WREG, 32'h0);
    check("wreg_rst", rd, 32'h0);
    apb(1'b0, OFF_STAT, 32'h0);
    check("stat_rst", rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    cmp_case(8'h10, 8'h20, 1'b0, 4'h5, 1'b0);
    cmp_case(8'h20, 8'h20, 1'b1, 4'h5, 1'b1);
    cmp_case(8'h21, 8'h20, 1'b0, 4'h3, 1'b1);
    cmp_case(8'h00, 8'hFF, 1'b1, 4'hA, 1'b1);
    cmp_case(8'hFE, 8'hFF, 1'b0, 4'hF, 1'b0);
    apb(1'b1, OFF_WREG, 32'h00000042);
    run(16'h0001, 1'b0, 1'b0);
    check("illegal_op", {31'h0, rd[STAT_ILLEGAL]}, 32'h1);
    apb(1'b0, OFF_WREG, 32'h0);
    check("illegal_w", rd, 32'h00000042);
    decadj_case(8'hA5, 1'b0, 1'b0);
    decadj_case(8'hCE, 1'b0, 1'b0);
    decadj_case(8'h12, 1'b0, 1'b1);
    decadj_case(8'h45, 1'b1, 1'b0);
    decadj_case(8'h38, 1'b0, 1'b0);
    decadj_case(8'h0A, 1'b1, 1'b0);
    end_of_test();
  end
endmodule : csda_core_tb
`default_nettype wire
